// ==== ssr_pkg.sv ====
// package of constants and types for the shutter sequencer readout block
package ssr_pkg;
   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int CLK_FREQ_HZ        = 10000000;
   localparam int HARD_RESET_WAIT_US = 10;
   localparam int HARD_RESET_WAIT_CYC =
      (HARD_RESET_WAIT_US * (CLK_FREQ_HZ / 1000000) > 0) ?
      HARD_RESET_WAIT_US * (CLK_FREQ_HZ / 1000000) : 1;
   localparam int MAX_RATE_10B_MBPS  = 620;
   localparam int MAX_RATE_8B_MBPS   = 496;
   // ----------------------------------------------------------------------
   // geometry and defaults
   // ----------------------------------------------------------------------
   localparam int ADC_BITS           = 10;
   localparam int ADC_CHANNELS       = 64;
   localparam int DATA_LANES         = 32;
   localparam int ROW_BITS           = 13;
   localparam int COL_BITS           = 13;
   localparam int CNT_BITS           = 16;
   localparam int STANDBY1_ADDR_LIM  = 40;
   localparam int SPI_ADDR_BITS      = 9;
   localparam logic [15:0] FTI_CYC_DEF = 16'h0004;
   localparam logic [15:0] RSI_CYC_DEF = 16'h0002;
   localparam logic [9:0]  CRC_SEED    = 10'h3FF;
   localparam logic [9:0]  CRC_POLY    = 10'h08D;
   // sync lane codes
   localparam logic [9:0]  SYNC_FS  = 10'h2AA;
   localparam logic [9:0]  SYNC_LS  = 10'h0AA;
   localparam logic [9:0]  SYNC_FE  = 10'h32A;
   localparam logic [9:0]  SYNC_LE  = 10'h12A;
   localparam logic [9:0]  SYNC_IMG = 10'h035;
   localparam logic [9:0]  SYNC_CRC = 10'h059;
   localparam logic [9:0]  SYNC_IDL = 10'h3A6;
   // ----------------------------------------------------------------------
   // modes and states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      SSR_PIPE_MASTER = 3'b000,
      SSR_PIPE_SLAVE  = 3'b001,
      SSR_TRIG_MASTER = 3'b010,
      SSR_TRIG_SLAVE  = 3'b011,
      SSR_ROLLING     = 3'b100
   } ssr_mode_type;
   typedef enum logic [2:0] {
      SSR_PWR_STBY_INT = 3'b000,
      SSR_PWR_STBY1    = 3'b001,
      SSR_PWR_STBY2    = 3'b010,
      SSR_PWR_IDLE     = 3'b011,
      SSR_PWR_RUN      = 3'b100
   } ssr_pwr_type;
   typedef enum logic [2:0] {
      SSR_SQ_WAIT  = 3'b000,
      SSR_SQ_INTEG = 3'b001,
      SSR_SQ_FTI   = 3'b010,
      SSR_SQ_RSI   = 3'b011,
      SSR_SQ_LINE  = 3'b100,
      SSR_SQ_CRC   = 3'b101,
      SSR_SQ_FEND  = 3'b110
   } ssr_seq_type;
endpackage : ssr_pkg

// ==== ssr_top.sv ====
// sequencer, lane formatters, sync lane and power ladder of the readout
`timescale 1ns/1ps
module ssr_top
   import ssr_pkg::*;
#(
   parameter int LANES   = DATA_LANES,
   parameter int WBITS   = ADC_BITS,
   parameter int FIFO_DW = 2 * ADC_BITS
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         trig_pin,
   input  wire logic                         link_clk,
   input  wire logic [2*LANES*WBITS-1:0]     adc_data,
   input  wire logic                         adc_valid,
   output logic                              adc_ready,
   input  wire logic                         cfg_we,
   input  wire logic [SPI_ADDR_BITS-1:0]     cfg_addr,
   input  wire logic                         cfg_reserved_done,
   input  wire logic                         cfg_blocks_on,
   input  wire logic                         seq_enable,
   input  wire logic [2:0]                   mode_sel,
   input  wire logic                         bits8_mode,
   input  wire logic [1:0]                   gain_sel,
   input  wire logic                         subsample,
   input  wire logic [CNT_BITS-1:0]          integ_time,
   input  wire logic [ROW_BITS-1:0]          win_row_start,
   input  wire logic [ROW_BITS-1:0]          win_row_end,
   input  wire logic [COL_BITS-1:0]          win_col_start,
   input  wire logic [COL_BITS-1:0]          win_col_end,
   output logic [LANES*WBITS-1:0]            lane_word,
   output logic [WBITS-1:0]                  sync_word,
   output logic                              word_valid,
   input  wire logic                         word_ready,
   output logic                              fwd_clk,
   output logic                              cfg_write_ok,
   output logic [2:0]                        pwr_state,
   output logic                              pix_reset,
   output logic                              pix_sample,
   output logic [ROW_BITS-1:0]               read_row,
   output logic [ROW_BITS-1:0]               reset_row,
   output logic [1:0]                        gain_act,
   output logic                              subsample_act
);
   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   logic [1:0] trig_sync_reg;
   logic [1:0] lclk_sync_reg;
   logic       trig_d_reg;
   logic       lclk_d_reg;
   // two sync flops per pin plus an edge flop; the first sync stage is never looked at
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_sync_reg <= 2'b00;
         lclk_sync_reg <= 2'b00;
         trig_d_reg    <= 1'b0;
         lclk_d_reg    <= 1'b0;
      end else begin
         trig_sync_reg <= {trig_sync_reg[0], trig_pin};
         lclk_sync_reg <= {lclk_sync_reg[0], link_clk};
         trig_d_reg    <= trig_sync_reg[1];
         lclk_d_reg    <= lclk_sync_reg[1];
      end
   end
   wire trig_lvl  = trig_sync_reg[1];
   wire trig_rise = trig_lvl & ~trig_d_reg;
   wire trig_fall = ~trig_lvl & trig_d_reg;
   wire word_tick = lclk_sync_reg[1] & ~lclk_d_reg; // one word per rising link edge

   // ----------------------------------------------------------------------
   // power ladder
   // ----------------------------------------------------------------------
   ssr_pwr_type pwr_reg;
   logic [CNT_BITS-1:0] hr_cnt_reg;
   // the wait after reset is the host's job; counted only to gate the ladder
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_reg    <= SSR_PWR_STBY1;
         hr_cnt_reg <= '0;
      end else begin
         if (hr_cnt_reg != CNT_BITS'(HARD_RESET_WAIT_CYC))
            hr_cnt_reg <= hr_cnt_reg + 1'b1;
         unique case (pwr_reg)
            SSR_PWR_STBY1:
               if (cfg_we && hr_cnt_reg == CNT_BITS'(HARD_RESET_WAIT_CYC))
                  pwr_reg <= SSR_PWR_STBY_INT;
            SSR_PWR_STBY_INT:
               if (cfg_reserved_done) pwr_reg <= SSR_PWR_STBY2;
            SSR_PWR_STBY2:
               if (cfg_blocks_on) pwr_reg <= SSR_PWR_IDLE;
            SSR_PWR_IDLE:
               if (!cfg_blocks_on) pwr_reg <= SSR_PWR_STBY2;
               else if (seq_enable) pwr_reg <= SSR_PWR_RUN;
            SSR_PWR_RUN:
               if (!seq_enable) pwr_reg <= SSR_PWR_IDLE;
            default: pwr_reg <= SSR_PWR_STBY1;
         endcase
      end
   end
   wire running = (pwr_reg == SSR_PWR_RUN);

   // write permission per state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cfg_write_ok <= 1'b0;
      else if (pwr_reg == SSR_PWR_STBY1)
         cfg_write_ok <= cfg_we && (cfg_addr < SPI_ADDR_BITS'(STANDBY1_ADDR_LIM));
      else
         cfg_write_ok <= cfg_we;
   end

   // ----------------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------------
   ssr_seq_type seq_reg;
   ssr_mode_type mode_reg;
   logic [CNT_BITS-1:0] cnt_reg;
   logic [CNT_BITS-1:0] integ_reg;
   logic [COL_BITS-1:0] col_reg;
   logic                int_run_reg;  // pipelined integration of next frame
   logic [CNT_BITS-1:0] int_cnt_reg;
   logic                frame_ready_reg;
   logic                trig_pend_reg;
   wire [COL_BITS-1:0] col_step = subsample_act ? COL_BITS'(4) : COL_BITS'(2);
   wire last_col = (col_reg + col_step > win_col_end);
   wire last_row = (read_row + (subsample_act ? 2'd2 : 2'd1) > win_row_end);
   wire is_slave = (mode_reg == SSR_PIPE_SLAVE) || (mode_reg == SSR_TRIG_SLAVE);
   // push qualifiers sit here because the sequencer below already reads them
   wire  in_line  = (seq_reg == SSR_SQ_LINE);
   wire  fifo_push_ok;
   wire  fifo_push = running && word_tick && fifo_push_ok &&
                     (in_line || seq_reg == SSR_SQ_CRC || seq_reg == SSR_SQ_FEND) &&
                     (!in_line || adc_valid);

   // settings latched only in the wait and frame-end states so no frame mixes two settings
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_act      <= 2'b00;
         subsample_act <= 1'b0;
         mode_reg      <= SSR_PIPE_MASTER;
         integ_reg     <= '0;
      end else if (seq_reg == SSR_SQ_WAIT || seq_reg == SSR_SQ_FEND) begin
         gain_act      <= gain_sel;
         subsample_act <= subsample;
         mode_reg      <= ssr_mode_type'(mode_sel);
         integ_reg     <= integ_time;
      end
   end

   // main sequence: wait, transfer, per line setup, read and crc, frame end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_reg    <= SSR_SQ_WAIT;
         cnt_reg    <= '0;
         col_reg    <= '0;
         read_row   <= '0;
         pix_sample <= 1'b0;
      end else if (!running) begin
         seq_reg    <= SSR_SQ_WAIT;
         pix_sample <= 1'b0;
      end else begin
         pix_sample <= 1'b0;
         unique case (seq_reg)
            SSR_SQ_WAIT: begin
               read_row <= win_row_start;
               if (mode_reg == SSR_ROLLING) seq_reg <= SSR_SQ_RSI;
               else if (frame_ready_reg) begin
                  seq_reg <= SSR_SQ_FTI;
                  cnt_reg <= '0;
               end
            end
            SSR_SQ_FTI: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == FTI_CYC_DEF - 1'b1) begin
                  pix_sample <= 1'b1;
                  seq_reg    <= SSR_SQ_RSI;
                  cnt_reg    <= '0;
               end
            end
            SSR_SQ_RSI: begin
               cnt_reg <= cnt_reg + 1'b1;
               col_reg <= win_col_start;
               if (cnt_reg == RSI_CYC_DEF - 1'b1) begin
                  seq_reg <= SSR_SQ_LINE;
                  cnt_reg <= '0;
               end
            end
            SSR_SQ_LINE:
               if (fifo_push) begin
                  col_reg <= col_reg + col_step;
                  if (last_col) seq_reg <= SSR_SQ_CRC;
               end
            SSR_SQ_CRC:
               if (fifo_push) begin
                  if (last_row) seq_reg <= SSR_SQ_FEND;
                  else begin
                     read_row <= read_row + (subsample_act ? 2'd2 : 2'd1);
                     seq_reg  <= SSR_SQ_RSI;
                  end
               end
            SSR_SQ_FEND:
               if (fifo_push) seq_reg <= SSR_SQ_WAIT;
            default: seq_reg <= SSR_SQ_WAIT;
         endcase
      end
   end

   // integration control, runs beside readout in pipelined modes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_reset       <= 1'b1;
         int_run_reg     <= 1'b0;
         int_cnt_reg     <= '0;
         frame_ready_reg <= 1'b0;
         trig_pend_reg   <= 1'b0;
      end else if (!running) begin
         pix_reset       <= 1'b1;
         int_run_reg     <= 1'b0;
         frame_ready_reg <= 1'b0;
         trig_pend_reg   <= 1'b0;
      end else begin
         if (seq_reg == SSR_SQ_FTI) frame_ready_reg <= 1'b0;
         if (trig_rise) trig_pend_reg <= 1'b1;
         unique case (mode_reg)
            SSR_PIPE_MASTER, SSR_TRIG_MASTER:
               if (!int_run_reg && !frame_ready_reg &&
                   (mode_reg == SSR_PIPE_MASTER || trig_pend_reg)) begin
                  int_run_reg   <= 1'b1;
                  pix_reset     <= 1'b0;
                  int_cnt_reg   <= '0;
                  trig_pend_reg <= 1'b0;
               end else if (int_run_reg) begin
                  int_cnt_reg <= int_cnt_reg + 1'b1;
                  if (int_cnt_reg >= integ_reg) begin
                     int_run_reg     <= 1'b0;
                     pix_reset       <= 1'b1;
                     frame_ready_reg <= 1'b1;
                  end
               end
            SSR_PIPE_SLAVE, SSR_TRIG_SLAVE: begin
               if (trig_rise && !frame_ready_reg) begin
                  int_run_reg <= 1'b1;
                  pix_reset   <= 1'b0;
               end
               if (trig_fall && int_run_reg) begin
                  int_run_reg     <= 1'b0;
                  pix_reset       <= 1'b1;
                  frame_ready_reg <= 1'b1;
               end
            end
            default: pix_reset <= 1'b0; // rolling: rows reset by pointer
         endcase
      end
   end

   // rolling reset pointer leads the read pointer by the exposure in rows
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) reset_row <= '0;
      else if (mode_reg == SSR_ROLLING)
         reset_row <= read_row + integ_reg[ROW_BITS-1:0];
      else reset_row <= '0;
   end

   // ----------------------------------------------------------------------
   // lane formatters: pair muxing and line crc
   // ----------------------------------------------------------------------
   logic [LANES*WBITS-1:0] fmt_word;
   logic [LANES*WBITS-1:0] crc_reg;
   logic                   phase_reg; // which converter of the pair goes next
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         wire [WBITS-1:0] a0 = adc_data[(2*g)*WBITS +: WBITS];
         wire [WBITS-1:0] a1 = adc_data[(2*g+1)*WBITS +: WBITS];
         wire [WBITS-1:0] smp0 = phase_reg ? a1 : a0;
         // 8-bit mode drops the two lsbs and keeps the top bits
         wire [WBITS-1:0] smp = bits8_mode ? {2'b00, smp0[WBITS-1:2]} : smp0;
         wire [WBITS-1:0] c = crc_reg[g*WBITS +: WBITS];
         wire [WBITS-1:0] cx = c ^ smp;
         wire [WBITS-1:0] cnext = {cx[WBITS-2:0], 1'b0} ^ (cx[WBITS-1] ? CRC_POLY : '0);
         assign fmt_word[g*WBITS +: WBITS] = in_line ? smp : c;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) crc_reg[g*WBITS +: WBITS] <= CRC_SEED;
            else if (seq_reg == SSR_SQ_RSI) crc_reg[g*WBITS +: WBITS] <= CRC_SEED;
            else if (fifo_push && in_line) crc_reg[g*WBITS +: WBITS] <= cnext;
         end
      end
   endgenerate

   // converter pair phase; a pair word is consumed after its second half
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) phase_reg <= 1'b0;
      else if (!in_line) phase_reg <= 1'b0;
      else if (fifo_push) phase_reg <= ~phase_reg;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) adc_ready <= 1'b0;
      else adc_ready <= fifo_push && in_line && phase_reg;
   end

   // sync lane code for the current word
   logic [WBITS-1:0] sync_code;
   always_comb begin
      unique case (seq_reg)
         SSR_SQ_LINE: sync_code = (col_reg == win_col_start) ?
                                  ((read_row == win_row_start) ? SYNC_FS : SYNC_LS)
                                  : SYNC_IMG;
         SSR_SQ_CRC:  sync_code = last_row ? SYNC_FE : SYNC_LE;
         SSR_SQ_FEND: sync_code = SYNC_CRC;
         default:     sync_code = SYNC_IDL;
      endcase
   end

   // ----------------------------------------------------------------------
   // two-entry output buffer
   // ----------------------------------------------------------------------
   localparam int BW = LANES*WBITS + WBITS;
   logic [BW-1:0] buf_mem [2];
   logic [1:0]    buf_cnt_reg;
   logic          wr_ptr_reg;
   logic          rd_ptr_reg;
   assign fifo_push_ok = (buf_cnt_reg != 2'd2); // full stalls the sequencer
   wire pop = word_valid && word_ready;
   wire take = (buf_cnt_reg != 2'd0) && (!word_valid || pop);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_cnt_reg <= 2'd0;
         wr_ptr_reg  <= 1'b0;
         rd_ptr_reg  <= 1'b0;
      end else begin
         if (fifo_push) wr_ptr_reg <= ~wr_ptr_reg;
         if (take) rd_ptr_reg <= ~rd_ptr_reg;
         buf_cnt_reg <= buf_cnt_reg + {1'b0, fifo_push} - {1'b0, take};
      end
   end
   always_ff @(posedge clk) begin
      if (fifo_push) buf_mem[wr_ptr_reg] <= {sync_code, fmt_word};
   end
   // output stage registered; held while the receiver stalls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_valid <= 1'b0;
         lane_word  <= '0;
         sync_word  <= SYNC_IDL;
      end else if (take) begin
         word_valid <= 1'b1;
         {sync_word, lane_word} <= buf_mem[rd_ptr_reg];
      end else if (pop) word_valid <= 1'b0;
   end
   // forwarded clock toggles with word timing so it stays aligned
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) fwd_clk <= 1'b0;
      else if (word_tick) fwd_clk <= ~fwd_clk;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pwr_state <= 3'b001;
      else pwr_state <= pwr_reg;
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   stby1_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pwr_reg == SSR_PWR_STBY1 && cfg_we && cfg_addr >= 9'd40) |=> !cfg_write_ok)
      else $error("write above limit accepted in first standby");
   gain_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (seq_reg == SSR_SQ_LINE) |=> $stable(gain_act))
      else $error("gain changed inside a frame");
   fti_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      (running && $rose(seq_reg == SSR_SQ_FTI)) |-> (seq_reg == SSR_SQ_FTI)[*4])
      else $error("frame transfer too short");
   slave_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      (running && is_slave && trig_rise && !frame_ready_reg) |=> !pix_reset)
      else $error("slave trigger did not start integration");
   slave_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      (running && is_slave && trig_fall && int_run_reg) |=> frame_ready_reg)
      else $error("slave falling edge did not end integration");
   run_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pwr_reg == SSR_PWR_IDLE && cfg_blocks_on && seq_enable) |=> running)
      else $error("sequencer enable did not start capture");
   buf_full_a: assert property (@(posedge clk) disable iff (!rst_n)
      (buf_cnt_reg == 2'd2) |-> !fifo_push)
      else $error("push into full buffer");
   buf_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (word_valid && !word_ready) |=> (word_valid && $stable(lane_word)))
      else $error("output word dropped under stall");
   frame_c: cover property (@(posedge clk) disable iff (!rst_n)
      seq_reg == SSR_SQ_FEND ##1 seq_reg == SSR_SQ_WAIT);
   stall_c: cover property (@(posedge clk) disable iff (!rst_n) buf_cnt_reg == 2'd2);
   slave_c: cover property (@(posedge clk) disable iff (!rst_n)
      running && is_slave && trig_fall);
endmodule : ssr_top

// ==== ssr_host_model.sv ====
// host side model: link clock source and a receiver that stalls
`timescale 1ns/1ps
// ----------------------------------------
// host receiver model
// ----------------------------------------
module ssr_host_model (
   input  wire logic clk,
   input  wire logic stall,
   output logic      link_clk,
   output logic      word_ready
);
   // odd start offset keeps the link clock edges off the clk edges
   initial begin
      link_clk = 1'b0;
      #137;
      forever #400 link_clk = ~link_clk;
   end
   // ready drops at random, and for good while stall is held
   initial word_ready = 1'b0;
   always @(negedge clk) word_ready <= !stall && ($urandom % 4 != 0);
endmodule : ssr_host_model

// ==== tb_top.sv ====
// self-checking bench for the shutter sequencer readout
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t %h %h", $time, a, b); end end
module tb_top
   import ssr_pkg::*;
;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic         clk, rst_n, trig_pin, adc_valid, cfg_we, done_r, blk_on, seq_en;
   logic         stall, got, held, link_clk, adc_ready, word_valid, word_ready, ok, pix_rst;
   logic [639:0] adc_data;
   logic [319:0] lane_word, lw;
   logic [15:0]  integ;
   logic [12:0]  row_end, col_end;
   logic [9:0]   sync_word, exp_w;
   logic [8:0]   cfg_addr;
   logic [2:0]   pwr;
   logic [1:0]   gain;
   logic [19:0]  pq[$];
   logic         ph;
   logic [9:0]   crc;
   logic [639:0] nd;
   int           error_cnt, n_compared, cyc, seed, n_img;
   ssr_host_model host (.clk(clk), .stall(stall), .link_clk(link_clk), .word_ready(word_ready));
   ssr_top dut (.clk(clk), .rst_n(rst_n), .trig_pin(trig_pin), .link_clk(link_clk),
      .adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready), .cfg_we(cfg_we),
      .cfg_addr(cfg_addr), .cfg_reserved_done(done_r), .cfg_blocks_on(blk_on),
      .seq_enable(seq_en), .mode_sel(3'h0), .bits8_mode(1'b0), .gain_sel(gain),
      .subsample(1'b0), .integ_time(integ), .win_row_start(13'h0000),
      .win_row_end(row_end), .win_col_start(13'h0000), .win_col_end(col_end),
      .lane_word(lane_word), .sync_word(sync_word), .word_valid(word_valid),
      .word_ready(word_ready), .fwd_clk(), .cfg_write_ok(ok), .pwr_state(pwr),
      .pix_reset(pix_rst), .pix_sample(), .read_row(), .reset_row(), .gain_act(),
      .subsample_act());
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [639:0] rnd();
      logic [639:0] d;
      for (int i = 0; i < 20; i++) d[i*32 +: 32] = $urandom;
      return d;
   endfunction : rnd
   // line check value: one shift per word, polynomial folded in on carry out
   function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [9:0] d);
      logic [9:0] x;
      x = c ^ d;
      return {x[8:0], 1'b0} ^ (x[9] ? CRC_POLY : 10'h000);
   endfunction : crc_step
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   // one config write; the accept flag is looked at one cycle on
   task automatic wr(input logic [8:0] a, input logic chk, input logic exp);
      @(negedge clk);
      cfg_we = 1'b1;
      cfg_addr = a;
      @(negedge clk);
      cfg_we = 1'b0;
      if (chk) `CHK(ok, exp)
   endtask : wr
   task automatic step(input logic [2:0] v);
      for (int i = 0; i < 50 && pwr !== v; i++) @(negedge clk);
      `CHK(pwr, v)
   endtask : step
   // scoreboard: each consumed pair gives lane 0 two words, first channel first
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin error_cnt++; final_report(); end
      got <= adc_ready;
      if (held) `CHK(lane_word, lw)
      held <= word_valid === 1'b1 && word_ready === 1'b0;
      lw <= lane_word;
      // a line that ends on a first half leaves its pair for the next line
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
         if (sync_word === SYNC_FS || sync_word === SYNC_LS) begin
            ph = 1'b0;
            crc = CRC_SEED;
         end
         if (sync_word === SYNC_FS || sync_word === SYNC_LS || sync_word === SYNC_IMG) begin
            exp_w = (pq.size() > 0) ? (ph ? pq[0][19:10] : pq[0][9:0]) : ~lane_word[9:0];
            if (ph && pq.size() > 0) void'(pq.pop_front());
            ph = ~ph;
            n_img++;
            `CHK(lane_word[9:0], exp_w)
            crc = crc_step(crc, exp_w);
         end else if (sync_word === SYNC_LE || sync_word === SYNC_FE) begin
            `CHK(lane_word[9:0], crc)
         end
      end
   end
   // new pair only after the old one was taken, so nothing is skipped
   always @(negedge clk) begin
      trig_pin <= 1'($urandom);
      if (got === 1'b1) begin
         nd = rnd();
         adc_data <= nd;
         pq.push_back(nd[19:0]);
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = $urandom(9);
      {rst_n, cfg_we, done_r, blk_on, seq_en, stall, got, held, trig_pin} = '0;
      adc_data = rnd();
      pq.push_back(adc_data[19:0]);
      ph = 1'b0;
      crc = CRC_SEED;
      adc_valid = 1'b1;
      cfg_addr = '0;
      gain = 2'($urandom);
      integ = 16'h0003 + 16'($urandom % 4);
      row_end = 13'h0001 + 13'($urandom % 2);
      col_end = 13'h0003 + 13'($urandom % 5);
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK({pwr, pix_rst, sync_word}, {3'h1, 1'b1, SYNC_IDL})
      rst_n = 1'b1;
      wr(9'h027, 1'b1, 1'b1);
      wr(9'h028, 1'b1, 1'b0);
      step(3'h1);
      repeat (100) @(negedge clk);
      wr(9'h020, 1'b0, 1'b0);
      step(3'h0);
      done_r = 1'b1;
      step(3'h2);
      wr(9'h1C0, 1'b1, 1'b1);
      blk_on = 1'b1;
      step(3'h3);
      seq_en = 1'b1;
      step(3'h4);
      repeat (1500) @(negedge clk);
      stall = 1'b1;
      repeat (80) @(negedge clk);
      stall = 1'b0;
      repeat (2500) @(negedge clk);
      `CHK(n_img > 0, 1'b1)
      final_report();
   end
endmodule : tb_top
